// ---- design/adsq_ctrl.v ----
`include "adsq_map.vh"

// Eight channel converter sequencer with APB registers
module adsq_ctrl
(
   // APB
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Trigger sources
   input  wire        reload_tmr_out,
   input  wire        frt_zero_det,
   // Analog front end
   input  wire        cmp_hi,
   output reg  [2:0]  chan_sel_q,
   output reg         sample_out_q,
   output reg  [9:0]  dac_out_q,
   // Completion
   output reg         irq_q,
   output reg         xfer_req_q,
   input  wire        xfer_ack
);

   localparam ST_IDLE = 2'h0;
   localparam ST_CONV = 2'h1;
   localparam ST_WAIT = 2'h2;
   localparam ST_NEXT = 2'h3;

   reg  [7:0]  ctrl_q;
   reg  [5:0]  chan_q;
   reg  [1:0]  st_q;
   reg  [9:0]  data_q;
   reg         unread_q;
   reg  [1:0]  irq_st_q;
   reg  [1:0]  irq_msk_q;
   reg         busy_q;
   reg         sw_start_q;
   reg         rl_s1_q, rl_s2_q, rl_s3_q;
   reg         zd_s1_q, zd_s2_q, zd_s3_q;
   reg         start_q;
   reg         pending_q;

   wire        sar_sample;
   wire [9:0]  sar_dac;
   wire        sar_done;
   wire [9:0]  sar_res;
   wire        wr_en;
   wire        rd_en;
   wire        trg_hit;
   wire        hold;
   wire [1:0]  mode;
   wire [2:0]  ch_start;
   wire [2:0]  ch_end;
   wire [1:0]  irq_set;

   assign wr_en    = psel && penable && pwrite;
   assign rd_en    = psel && penable && !pwrite;
   assign mode     = ctrl_q[`ADSQ_CTRL_MODE_H:`ADSQ_CTRL_MODE_L];
   assign ch_start = chan_q[2:0];
   assign ch_end   = chan_q[5:3];

   // ----------------------------------------
   // Trigger capture
   // ----------------------------------------
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rl_s1_q <= 1'b0;
         rl_s2_q <= 1'b0;
         rl_s3_q <= 1'b0;
         zd_s1_q <= 1'b0;
         zd_s2_q <= 1'b0;
         zd_s3_q <= 1'b0;
      end
      else
      begin
         rl_s1_q <= reload_tmr_out;
         rl_s2_q <= rl_s1_q;
         rl_s3_q <= rl_s2_q;
         zd_s1_q <= frt_zero_det;
         zd_s2_q <= zd_s1_q;
         zd_s3_q <= zd_s2_q;
      end
   end

   // Only the selected source can start; others are ignored
   assign trg_hit =
      (ctrl_q[`ADSQ_CTRL_TRG_H:`ADSQ_CTRL_TRG_L] == `ADSQ_TRG_SOFT &&
       sw_start_q) ||
      (ctrl_q[`ADSQ_CTRL_TRG_H:`ADSQ_CTRL_TRG_L] == `ADSQ_TRG_RELOAD &&
       rl_s2_q && !rl_s3_q) ||
      (ctrl_q[`ADSQ_CTRL_TRG_H:`ADSQ_CTRL_TRG_L] == `ADSQ_TRG_ZERO &&
       zd_s2_q && !zd_s3_q);

   // Unread result with interrupt enabled stalls the next conversion
   assign hold = unread_q && irq_msk_q[`ADSQ_IRQ_DONE];

   assign irq_set = {1'b0, sar_done};

   // ----------------------------------------
   // Conversion engine
   // ----------------------------------------
   adsq_sar u_sar
   (
      .pclk     (pclk),
      .presetn  (presetn),
      .start    (start_q),
      .res10    (ctrl_q[`ADSQ_CTRL_RES10]),
      .cmp_hi   (cmp_hi),
      .sample_q (sar_sample),
      .dac_q    (sar_dac),
      .done_q   (sar_done),
      .result_q (sar_res)
   );

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_q       <= ST_IDLE;
         busy_q     <= 1'b0;
         start_q    <= 1'b0;
         pending_q  <= 1'b0;
         chan_sel_q <= 3'h0;
      end
      else
      begin
         start_q <= 1'b0;
         case (st_q)
            ST_IDLE:
            begin
               if (trg_hit)
               begin
                  busy_q     <= 1'b1;
                  chan_sel_q <= ch_start;
                  pending_q  <= 1'b1;
                  st_q       <= ST_NEXT;
               end
            end
            ST_NEXT:
            begin
               if (ctrl_q[`ADSQ_CTRL_STOP])
               begin
                  busy_q <= 1'b0;
                  st_q   <= ST_IDLE;
               end
               else if (pending_q && !hold)
               begin
                  start_q   <= 1'b1;
                  pending_q <= 1'b0;
                  st_q      <= ST_CONV;
               end
            end
            ST_CONV:
            begin
               if (sar_done)
               begin
                  if (chan_sel_q != ch_end)
                  begin
                     chan_sel_q <= chan_sel_q + 3'h1;
                     pending_q  <= 1'b1;
                     st_q       <= ST_NEXT;
                  end
                  else if (mode == `ADSQ_MODE_CONT)
                  begin
                     chan_sel_q <= ch_start;
                     pending_q  <= 1'b1;
                     st_q       <= ST_NEXT;
                  end
                  else if (mode == `ADSQ_MODE_INCR)
                  begin
                     busy_q <= 1'b0;
                     st_q   <= ST_WAIT;
                  end
                  else
                  begin
                     busy_q <= 1'b0;
                     st_q   <= ST_IDLE;
                  end
               end
            end
            ST_WAIT:
            begin
               if (ctrl_q[`ADSQ_CTRL_STOP])
                  st_q <= ST_IDLE;
               else if (trg_hit)
               begin
                  busy_q     <= 1'b1;
                  chan_sel_q <= ch_start;
                  pending_q  <= 1'b1;
                  st_q       <= ST_NEXT;
               end
            end
            default:
               st_q <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Registers and APB slave
   // ----------------------------------------
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_q     <= `ADSQ_RST_CTRL;
         chan_q     <= `ADSQ_RST_CHAN;
         sw_start_q <= 1'b0;
         data_q     <= 10'h000;
         unread_q   <= 1'b0;
         irq_st_q   <= 2'h0;
         irq_msk_q  <= 2'h0;
         prdata     <= 32'h00000000;
         pready     <= 1'b0;
         pslverr    <= 1'b0;
      end
      else
      begin
         sw_start_q <= 1'b0;
         pready     <= psel && !penable;
         pslverr    <= 1'b0;
         if (wr_en && pready)
         begin
            case (paddr)
               `ADSQ_OFF_CTRL:
               begin
                  ctrl_q     <= pwdata[7:0];
                  sw_start_q <= pwdata[`ADSQ_CTRL_START] && !busy_q;
               end
               `ADSQ_OFF_CHAN:   chan_q    <= pwdata[5:0];
               `ADSQ_OFF_IRQMSK: irq_msk_q <= pwdata[1:0];
               `ADSQ_OFF_IRQST:  ;
               default:          pslverr <= 1'b0;
            endcase
         end
         if (psel && !penable)
         begin
            case (paddr)
               `ADSQ_OFF_CTRL:  prdata <= {24'h000000, ctrl_q};
               `ADSQ_OFF_CHAN:  prdata <= {26'h0000000, chan_q};
               `ADSQ_OFF_STAT:
                  prdata <= {27'h0000000, unread_q, st_q, busy_q,
                             ctrl_q[`ADSQ_CTRL_RES10]};
               `ADSQ_OFF_DATA:  prdata <= {22'h000000, data_q};
               `ADSQ_OFF_IRQST: prdata <= {30'h00000000, irq_st_q};
               `ADSQ_OFF_IRQMSK: prdata <= {30'h00000000, irq_msk_q};
               default:
               begin
                  prdata  <= 32'h00000000;
                  pslverr <= 1'b1;
               end
            endcase
         end
         // Data read or transfer acknowledge frees the result
         if ((rd_en && pready && paddr == `ADSQ_OFF_DATA) || xfer_ack)
            unread_q <= 1'b0;
         if (sar_done)
         begin
            if (ctrl_q[`ADSQ_CTRL_RES10])
               data_q <= sar_res;
            else
               data_q <= {2'h0, sar_res[9:2]};
            unread_q <= 1'b1;
         end
         // Set wins over write-one-to-clear
         if (wr_en && pready && paddr == `ADSQ_OFF_IRQST)
            irq_st_q <= (irq_st_q & ~pwdata[1:0]) | irq_set;
         else
            irq_st_q <= irq_st_q | irq_set;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_q        <= 1'b0;
         xfer_req_q   <= 1'b0;
         sample_out_q <= 1'b0;
         dac_out_q    <= 10'h000;
      end
      else
      begin
         irq_q        <= |(irq_st_q & irq_msk_q);
         sample_out_q <= sar_sample;
         dac_out_q    <= sar_dac;
         // Transfer request holds until the service acknowledges
         // A new completion wins over an acknowledge in the same cycle
         if (sar_done && ctrl_q[`ADSQ_CTRL_XFER])
            xfer_req_q <= 1'b1;
         else if (xfer_ack)
            xfer_req_q <= 1'b0;
      end
   end

endmodule // adsq_ctrl

// ---- design/adsq_map.vh ----
//
// Summary of operation
// - Result is 8 or 10 bits, software chosen
// - Eight inputs; software picks channel or group
// - Sample and hold first, then successive approximation
// - Whole conversion at least 6.13 us
// - Sampling phase at least 2.0 us
// - Start by software, reload edge, zero-detect edge
// - Completion raises request, may start transfer service
// - Completion request serviceable by transfer service
// - Interrupt enabled: unread result not overwritten
// - Two single-shot modes, one pass each
// - Single-shot single channel: convert once, stop; code runs ch_start to ch_end as in scan
// - Single-shot scan: each channel once, stop
// - Continuous: repeat channel or group forever
// - Incremental: one pass, wait next trigger
//
`ifndef ADSQ_MAP_VH
`define ADSQ_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADSQ_OFF_CTRL    12'h000
`define ADSQ_OFF_CHAN    12'h004
`define ADSQ_OFF_STAT    12'h008
`define ADSQ_OFF_DATA    12'h00C
`define ADSQ_OFF_IRQST   12'h010
`define ADSQ_OFF_IRQMSK  12'h014

// ----------------------------------------
// Control fields
// ----------------------------------------
`define ADSQ_CTRL_START  0
`define ADSQ_CTRL_RES10  1
`define ADSQ_CTRL_MODE_L 2
`define ADSQ_CTRL_MODE_H 3
`define ADSQ_CTRL_TRG_L  4
`define ADSQ_CTRL_TRG_H  5
`define ADSQ_CTRL_XFER   6
`define ADSQ_CTRL_STOP   7

`define ADSQ_MODE_SINGLE1 2'h0
`define ADSQ_MODE_SINGLE2 2'h1
`define ADSQ_MODE_CONT    2'h2
`define ADSQ_MODE_INCR    2'h3

`define ADSQ_TRG_SOFT    2'h0
`define ADSQ_TRG_RELOAD  2'h1
`define ADSQ_TRG_ZERO    2'h2

// ----------------------------------------
// Status and interrupt bits
// ----------------------------------------
`define ADSQ_IRQ_DONE    0
`define ADSQ_IRQ_OVR     1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ADSQ_RST_CTRL    8'h00
`define ADSQ_RST_CHAN    6'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define ADSQ_CLK_MHZ      125
`define ADSQ_CONV_NS      6130
`define ADSQ_SAMPLE_NS    2000
`define ADSQ_SAMPLE_CYC   ((`ADSQ_SAMPLE_NS*`ADSQ_CLK_MHZ+999)/1000)
`define ADSQ_CONV_CYC     ((`ADSQ_CONV_NS*`ADSQ_CLK_MHZ+999)/1000)
`define ADSQ_BITS_CYC     (`ADSQ_CONV_CYC-`ADSQ_SAMPLE_CYC)
`define ADSQ_STEP10_CYC   ((`ADSQ_BITS_CYC+9)/10)
`define ADSQ_STEP8_CYC    ((`ADSQ_BITS_CYC+7)/8)

`endif

// ---- design/adsq_sar.v ----
`include "adsq_map.vh"

// Successive approximation engine: hold, then one bit per step
module adsq_sar
(
   // Clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // Control
   input  wire        start,
   input  wire        res10,
   // Comparator
   input  wire        cmp_hi,
   // Analog side
   output reg         sample_q,
   output reg  [9:0]  dac_q,
   // Result
   output reg         done_q,
   output reg  [9:0]  result_q
);

   reg  [9:0]  mask_q;
   reg  [9:0]  cnt_q;
   reg  [3:0]  bit_q;
   reg         run_q;
   reg         cmp_s1_q;
   reg         cmp_s2_q;
   wire [9:0]  step_len;

   // Integer counts cut to the counter width on purpose
   localparam [31:0] SAMP_LAST = `ADSQ_SAMPLE_CYC - 1;
   localparam [31:0] STEP10    = `ADSQ_STEP10_CYC;
   localparam [31:0] STEP8     = `ADSQ_STEP8_CYC;

   assign step_len = res10 ? STEP10[9:0] : STEP8[9:0];

   // ----------------------------------------
   // Comparator synchroniser
   // ----------------------------------------
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cmp_s1_q <= 1'b0;
         cmp_s2_q <= 1'b0;
      end
      else
      begin
         cmp_s1_q <= cmp_hi;
         cmp_s2_q <= cmp_s1_q;
      end
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sample_q <= 1'b0;
         run_q    <= 1'b0;
         dac_q    <= 10'h000;
         mask_q   <= 10'h000;
         cnt_q    <= 10'h000;
         bit_q    <= 4'h0;
         done_q   <= 1'b0;
         result_q <= 10'h000;
      end
      else
      begin
         done_q <= 1'b0;
         if (start && !sample_q && !run_q)
         begin
            sample_q <= 1'b1;
            cnt_q    <= SAMP_LAST[9:0];
         end
         else if (sample_q)
         begin
            if (cnt_q == 10'h000)
            begin
               sample_q <= 1'b0;
               run_q    <= 1'b1;
               // Both widths start at the top so 8 bits span full scale
               mask_q   <= 10'h200;
               dac_q    <= 10'h200;
               bit_q    <= res10 ? 4'hA : 4'h8;
               cnt_q    <= step_len - 10'h001;
            end
            else
               cnt_q <= cnt_q - 10'h001;
         end
         else if (run_q)
         begin
            if (cnt_q != 10'h000)
               cnt_q <= cnt_q - 10'h001;
            else
            begin
               // Keep the trial bit only if input sits above the DAC
               if (!cmp_s2_q)
                  dac_q <= (dac_q & ~mask_q) | (mask_q >> 1);
               else
                  dac_q <= dac_q | (mask_q >> 1);
               mask_q <= mask_q >> 1;
               bit_q  <= bit_q - 4'h1;
               cnt_q  <= step_len - 10'h001;
               if (bit_q == 4'h1)
               begin
                  run_q    <= 1'b0;
                  done_q   <= 1'b1;
                  result_q <= cmp_s2_q ? dac_q : (dac_q & ~mask_q);
               end
            end
         end
      end
   end

endmodule // adsq_sar

// ---- verification/adsq_ctrl_sva.sv ----
module adsq_ctrl_sva
(
   // Clock and reset
   input logic        pclk,
   input logic        presetn,
   // APB
   input logic        psel,
   input logic        penable,
   input logic        pready,
   // Analog front end
   input logic [2:0]  chan_sel_q,
   input logic        sample_out_q,
   input logic [9:0]  dac_out_q,
   // Completion
   input logic        irq_q,
   input logic        xfer_req_q,
   input logic        xfer_ack
);
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------
   // Helper counters
   // ----------------------------------------
   // 2.0 us and 6.13 us at 125 MHz, rounded up
   localparam int SAMP_MIN = 250;
   localparam int CONV_MIN = 767;
   logic [11:0] samp_cnt_q;
   logic [11:0] conv_cnt_q;
   logic        seen_q;

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         samp_cnt_q <= 12'h000;
         conv_cnt_q <= 12'h000;
         seen_q     <= 1'b0;
      end
      else
      begin
         samp_cnt_q <= sample_out_q ? samp_cnt_q + 12'h001 : 12'h000;
         // Saturate so a long idle gap never wraps below the bound
         if (sample_out_q && samp_cnt_q == 12'h000)
            conv_cnt_q <= 12'h001;
         else if (conv_cnt_q != 12'hFFF)
            conv_cnt_q <= conv_cnt_q + 12'h001;
         seen_q <= seen_q | sample_out_q;
      end

   default clocking dc @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_samp_go;
      $rose(sample_out_q);
   endsequence

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_setup_answer: assert property (s_setup |=> pready)
      else $error("pready missing after setup");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("pready outside access phase");
   a_sample_len: assert property
      ($fell(sample_out_q) |-> samp_cnt_q >= SAMP_MIN)
      else $error("sampling phase too short");
   a_conv_period: assert property
      (s_samp_go ##0 seen_q |-> conv_cnt_q >= CONV_MIN)
      else $error("conversion shorter than minimum");
   a_chan_steady: assert property
      (sample_out_q && $past(sample_out_q) |-> $stable(chan_sel_q))
      else $error("channel changed while sampling");
   a_dac_steady: assert property
      (sample_out_q && $past(sample_out_q) |-> $stable(dac_out_q))
      else $error("trial code moved while sampling");
   a_xfer_hold: assert property (xfer_req_q && !xfer_ack |=> xfer_req_q)
      else $error("transfer request dropped early");
   a_xfer_drop: assert property
      (xfer_req_q && xfer_ack && irq_q |=> !xfer_req_q)
      else $error("transfer request kept after ack");
   a_protect_hold: assert property
      (s_samp_go |-> !($past(xfer_req_q) && $past(irq_q)))
      else $error("conversion started over unread result");
endmodule // adsq_ctrl_sva

bind adsq_ctrl adsq_ctrl_sva u_sva
(
   .pclk         (pclk),
   .presetn      (presetn),
   .psel         (psel),
   .penable      (penable),
   .pready       (pready),
   .chan_sel_q   (chan_sel_q),
   .sample_out_q (sample_out_q),
   .dac_out_q    (dac_out_q),
   .irq_q        (irq_q),
   .xfer_req_q   (xfer_req_q),
   .xfer_ack     (xfer_ack)
);

// ---- verification/adsq_afe_model.sv ----
module adsq_afe_model
(
   // Clock
   input  logic       pclk,
   // From converter
   input  logic [2:0] chan_sel_q,
   input  logic       sample_out_q,
   input  logic [9:0] dac_out_q,
   // To converter
   output logic       cmp_hi
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] held_q;

   initial held_q = 10'h000;
   // Track while sampling, hold during approximation
   always @(posedge pclk)
      if (sample_out_q)
         held_q <= 10'h055 + 10'h071 * {7'h00, chan_sel_q};
   // Half-code offset: input never ties with a trial code
   assign cmp_hi = {held_q, 1'b1} > {dac_out_q, 1'b0};
endmodule // adsq_afe_model

// ---- verification/test_adsq_ctrl.sv ----
`include "adsq_map.vh"
module test_adsq_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        reload_tmr_out, frt_zero_det, cmp_hi, sample_out_q;
   logic        irq_q, xfer_req_q, xfer_ack, err;
   logic [2:0]  chan_sel_q;
   logic [9:0]  dac_out_q;
   logic [2:0]  chq[$];
   int          miscompares, cmp_count, rises, cyc, r0, i, t;

   adsq_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .reload_tmr_out(reload_tmr_out), .frt_zero_det(frt_zero_det),
      .cmp_hi(cmp_hi), .chan_sel_q(chan_sel_q), .sample_out_q(sample_out_q),
      .dac_out_q(dac_out_q), .irq_q(irq_q), .xfer_req_q(xfer_req_q),
      .xfer_ack(xfer_ack));
   adsq_afe_model afe (.pclk(pclk), .chan_sel_q(chan_sel_q),
      .sample_out_q(sample_out_q), .dac_out_q(dac_out_q), .cmp_hi(cmp_hi));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   initial
   begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 80000)
      begin
         miscompares++;
         report_and_stop;
      end
   end

   // Count and log each new sampling phase
   logic samp_prev;
   always @(posedge pclk)
   begin
      if (sample_out_q === 1'b1 && samp_prev === 1'b0)
      begin
         rises++;
         chq.push_back(chan_sel_q);
      end
      samp_prev <= sample_out_q;
   end

   function automatic logic [9:0] lvl(input logic [2:0] ch);
      lvl = 10'h055 + 10'h071 * {7'h00, ch};
   endfunction

   task automatic report_and_stop;
      $display("counts: %0d compares, %0d mismatches", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input string n, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e)
      begin
         $display("mismatch %s expected %h seen %h", n, e, g);
         miscompares++;
      end
   endtask

   // Holds the request until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e,
                         input string n);
      apb(1'b0, a, 32'h0);
      check(n, e, rd);
   endtask

   task automatic set(input logic [31:0] c, input logic [2:0] s, e);
      apb(1'b1, `ADSQ_OFF_CHAN, {26'h0, e, s});
      apb(1'b1, `ADSQ_OFF_CTRL, c);
   endtask

   task automatic wait_more(input int n);
      int k;
      k = rises + n;
      for (int j = 0; j < 20000 && rises < k; j++)
         @(posedge pclk);
   endtask

   // Poll busy in STAT until it reads low, for at most 3000 reads
   task automatic wait_idle;
      rd = 32'h2;
      for (int j = 0; j < 3000 && rd[1] !== 1'b0; j++)
         apb(1'b0, `ADSQ_OFF_STAT, 32'h0);
   endtask

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      {presetn, psel, penable, pwrite, reload_tmr_out, frt_zero_det} = 0;
      {paddr, pwdata, xfer_ack} = 0;
      {miscompares, cmp_count, rises, cyc, t} = 0;
      samp_prev = 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(`ADSQ_OFF_CTRL, 32'h0, "ctrl_reset");
      rd_chk(`ADSQ_OFF_IRQMSK, 32'h0, "mask_reset");
      apb(1'b0, 12'h020, 32'h0);
      check("unmapped_err", 32'h1, {31'h0, err});
      $display("test reset done");

      apb(1'b1, `ADSQ_OFF_IRQMSK, 32'h1);
      set(32'h03, 3'd2, 3'd2);
      wait_more(1);
      wait_idle;
      check("irq_on", 32'h1, {31'h0, irq_q});
      rd_chk(`ADSQ_OFF_DATA, {22'h0, lvl(2)}, "single");
      apb(1'b1, `ADSQ_OFF_IRQST, 32'h1);
      rd_chk(`ADSQ_OFF_IRQST, 32'h0, "done_clear");
      check("irq_off", 32'h0, {31'h0, irq_q});
      $display("test single done");

      apb(1'b1, `ADSQ_OFF_IRQMSK, 32'h0);
      chq.delete();
      r0 = rises;
      set(32'h07, 3'd5, 3'd7);
      wait_more(3);
      wait_idle;
      check("scan_count", r0 + 3, rises);
      for (i = 0; i < 3; i++)
         check("scan_order", 5 + i, {29'h0, chq[i]});
      rd_chk(`ADSQ_OFF_DATA, {22'h0, lvl(7)}, "scan_last");
      check("irq_masked", 32'h0, {31'h0, irq_q});
      rd_chk(`ADSQ_OFF_IRQST, 32'h1, "flag_masked");
      apb(1'b1, `ADSQ_OFF_IRQST, 32'h1);
      $display("test scan done");

      for (t = 1; t < 3; t++)
      begin
         set(t == 1 ? 32'h10 : 32'h22, 3'(4 - t), 3'(4 - t));
         if (t == 1)
            reload_tmr_out <= 1'b1;
         else
            frt_zero_det <= 1'b1;
         repeat (4) @(posedge pclk);
         reload_tmr_out <= 1'b0;
         frt_zero_det <= 1'b0;
         wait_more(1);
         wait_idle;
         rd_chk(`ADSQ_OFF_DATA, t == 1 ? {22'h0, lvl(3) >> 2} :
                {22'h0, lvl(2)}, "trigger");
      end
      $display("test triggers done");

      set(32'h0F, 3'd0, 3'd1);
      wait_more(2);
      wait_idle;
      r0 = rises;
      repeat (1500) @(posedge pclk);
      check("incr_pause", r0, rises);
      apb(1'b1, `ADSQ_OFF_CTRL, 32'h0F);
      wait_more(2);
      wait_idle;
      check("incr_next", r0 + 2, rises);
      $display("test incremental done");

      set(32'h0B, 3'd4, 3'd4);
      wait_more(3);
      apb(1'b1, `ADSQ_OFF_CTRL, 32'h8A);
      wait_idle;
      rd_chk(`ADSQ_OFF_DATA, {22'h0, lvl(4)}, "cont");
      $display("test continuous done");

      apb(1'b1, `ADSQ_OFF_IRQMSK, 32'h1);
      set(32'h4B, 3'd6, 3'd6);
      for (i = 0; i < 3000 && xfer_req_q !== 1'b1; i++)
         @(posedge pclk);
      r0 = rises;
      repeat (2000) @(posedge pclk);
      check("protect", r0, rises);
      check("xfer_req", 32'h1, {31'h0, xfer_req_q});
      xfer_ack <= 1'b1;
      @(posedge pclk);
      xfer_ack <= 1'b0;
      wait_more(1);
      check("resumed", r0 + 1, rises);
      apb(1'b1, `ADSQ_OFF_CTRL, 32'hCA);
      for (i = 0; i < 3000 && xfer_req_q !== 1'b1; i++)
         @(posedge pclk);
      xfer_ack <= 1'b1;
      @(posedge pclk);
      xfer_ack <= 1'b0;
      wait_idle;
      rd_chk(`ADSQ_OFF_DATA, {22'h0, lvl(6)}, "xfer_data");
      $display("test transfer done");
      report_and_stop;
   end
endmodule // test_adsq_ctrl
